// [prc_pkg.sv]
package prc_pkg;

   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned BE_W   = 4;
   localparam int unsigned REG_W  = 16;
   localparam int unsigned XT_W   = 8;
   localparam int unsigned TRIM_W = 3;
   localparam int unsigned MV_W   = 12;

   // printed offsets are halfword addresses; word index is offset minus base
   localparam logic [31:0] REG_BASE       = 32'h5000_0000;
   localparam logic [31:0] XTAL_STAT_OFS  = 32'h5000_0032;
   localparam logic [31:0] PWR_CTRL_OFS   = 32'h5000_0052;
   localparam logic [31:0] PWR_LEVEL_OFS  = 32'h5000_0054;
   localparam logic [ADDR_W-1:0] XTAL_STAT_IDX =
      ADDR_W'(XTAL_STAT_OFS - REG_BASE);
   localparam logic [ADDR_W-1:0] PWR_CTRL_IDX  =
      ADDR_W'(PWR_CTRL_OFS - REG_BASE);
   localparam logic [ADDR_W-1:0] PWR_LEVEL_IDX =
      ADDR_W'(PWR_LEVEL_OFS - REG_BASE);

   // power_control field positions
   localparam int unsigned JOIN_MODE_BIT   = 15;
   localparam int unsigned HI_HYST_OFF_BIT = 14;
   localparam int unsigned HI_HYST_LVL_BIT = 13;
   localparam int unsigned HI_MON_OFF_BIT  = 12;
   localparam int unsigned LO_HYST_OFF_BIT = 11;
   localparam int unsigned LO_HYST_LVL_BIT = 10;
   localparam int unsigned LO_MON_OFF_BIT  = 9;
   localparam int unsigned PUMP_OFF_BIT    = 8;
   localparam int unsigned REF_HOLD_BIT    = 7;
   localparam int unsigned LOW_MODE_LSB    = 5;
   localparam int unsigned CORE_OFF_BIT    = 4;
   localparam int unsigned CORE_RET_BIT    = 3;
   localparam int unsigned JOIN_CLOSE_BIT  = 2;
   localparam int unsigned HI_OK_EN_BIT    = 1;
   localparam int unsigned HI_NOK_EN_BIT   = 0;
   localparam logic [REG_W-1:0] CTRL_RESET = 16'h4000;
   localparam logic [REG_W-1:0] CTRL_MASK  = 16'hFFFF;

   // power_level_trim field positions
   localparam int unsigned CONV_TRIM_LSB  = 11;
   localparam int unsigned CONV_LEVEL_LSB = 9;
   localparam int unsigned XTAL_TRIM_LSB  = 4;
   localparam int unsigned LOW_TRIM_LSB   = 1;
   localparam logic [REG_W-1:0] LEVEL_RESET = 16'h1A3E;
   localparam logic [REG_W-1:0] LEVEL_MASK  = 16'h3E7E;
   localparam logic [XT_W-1:0]  XTAL_RESET  = 8'h00;

   localparam logic [TRIM_W-1:0] TRIM_ZERO_CODE = 3'h3;
   localparam logic [MV_W-1:0] TRIM_STEP_MV = 12'h019;
   localparam logic [MV_W-1:0] TRIM_BIAS_MV = 12'h04B;
   localparam logic [MV_W-1:0] XTAL_NOM_MV  = 12'h384;
   localparam logic [MV_W-1:0] LOW_NOM_MV   = 12'h44C;
   localparam logic [MV_W-1:0] CONV_1V1_MV  = 12'h44C;
   localparam logic [MV_W-1:0] CONV_1V8_MV  = 12'h708;
   localparam logic [MV_W-1:0] CONV_2V5_MV  = 12'h9C4;
   localparam logic [MV_W-1:0] CONV_3V0_MV  = 12'hBB8;

   typedef enum logic [1:0] {
      PRC_HI_ACT_OFF_SLEEP,
      PRC_ALWAYS_OFF,
      PRC_LOW_BOTH,
      PRC_HI_ACT_LOW_SLEEP
   } prc_low_mode_e;

   typedef enum logic {PRC_BUS_IDLE, PRC_BUS_ANSWER} prc_bus_e;

   function automatic logic [MV_W-1:0] prc_conv_nominal(
      input logic [1:0] sel);
      logic [MV_W-1:0] v;
      v = CONV_1V1_MV;
      unique case (sel)
         2'h0: v = CONV_1V1_MV;
         2'h1: v = CONV_1V8_MV;
         2'h2: v = CONV_2V5_MV;
         2'h3: v = CONV_3V0_MV;
      endcase
      return v;
   endfunction

endpackage

// [prc_trim_level.sv]
`timescale 1ns/100ps
module prc_trim_level
   import prc_pkg::*;
#(
   parameter logic [prc_pkg::MV_W-1:0] RESET_MV = 12'h384
) (
   input  wire logic                        clk,
   input  wire logic                        reset_n,
   input  wire logic [prc_pkg::MV_W-1:0]    nominal_mv,
   input  wire logic [prc_pkg::TRIM_W-1:0]  code,
   output logic      [prc_pkg::MV_W-1:0]    level_mv
);

   logic [MV_W-1:0] level_ff;
   logic [MV_W-1:0] nxt_level;

   // code 011 is the zero point, each step 25 mV
   function automatic logic [MV_W-1:0] trim_apply(
      input logic [MV_W-1:0]   nom,
      input logic [TRIM_W-1:0] c);
      logic [MV_W-1:0] step;
      step = MV_W'(TRIM_STEP_MV * {{(MV_W-TRIM_W){1'b0}}, c});
      return MV_W'(nom + step - TRIM_BIAS_MV);
   endfunction

   always_comb begin
      nxt_level = trim_apply(nominal_mv, code);
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         level_ff <= RESET_MV;
      end else begin
         level_ff <= nxt_level;
      end
   end

   assign level_mv = level_ff;

endmodule

// [prc_low_reg_decode.sv]
`timescale 1ns/100ps
module prc_low_reg_decode
   import prc_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       reset_n,
   input  wire logic [1:0] mode,
   input  wire logic       sleep_mode,
   output logic            reg_on,
   output logic            high_current
);

   logic on_ff;
   logic high_ff;
   logic nxt_on;
   logic nxt_high;
   prc_low_mode_e m;

   always_comb begin
      m        = prc_low_mode_e'(mode);
      nxt_on   = 1'b0;
      nxt_high = 1'b0;
      unique case (m)
         PRC_HI_ACT_OFF_SLEEP: begin
            nxt_on   = !sleep_mode;
            nxt_high = !sleep_mode;
         end
         PRC_ALWAYS_OFF: begin
            nxt_on   = 1'b0;
            nxt_high = 1'b0;
         end
         PRC_LOW_BOTH: begin
            nxt_on   = 1'b1;
            nxt_high = 1'b0;
         end
         PRC_HI_ACT_LOW_SLEEP: begin
            nxt_on   = 1'b1;
            nxt_high = !sleep_mode;
         end
      endcase
   end

   // reset matches mode 00 while active
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         on_ff   <= 1'b1;
         high_ff <= 1'b1;
      end else begin
         on_ff   <= nxt_on;
         high_ff <= nxt_high;
      end
   end

   assign reg_on       = on_ff;
   assign high_current = high_ff;

endmodule

// [prc_regs.sv]
// Implementation choice: register access over Avalon-MM.
`timescale 1ns/100ps
// Operation
// R01: bit 15 picks manual or boost-only automatic join
// R02: manual mode: bit 2 closes rail switch
// R03: bits 13/10 pick monitor hysteresis level
// R04: bit 8 turns core pump off
// R05: bit 7 forces regulator references to hold
// R06: bits 6:5 decode low regulator mode
// R07: bit 3 enables core regulator retention
// R08: converter trim 13:11, 25 mV steps, reset 011
// R09: crystal regulator trim 6:4 around 0.9 V
// R10: low regulator trim 3:1 around 1.1 V
// R11: low regulator trim resets to 111
// R12: read-only crystal trim readback, writes ignored
// R13: bits 14/11 disable hysteresis, 14 resets high
// R14: bits 12,9,4,1,0 drive active-high controls
// R15: reads return stored fields, reserved bits zero
module prc_regs
   import prc_pkg::*;
(
   input  wire logic                       clk,
   input  wire logic                       reset_n,
   input  wire logic [prc_pkg::ADDR_W-1:0] avs_address,
   input  wire logic                       avs_read,
   input  wire logic                       avs_write,
   input  wire logic [prc_pkg::DATA_W-1:0] avs_writedata,
   input  wire logic [prc_pkg::BE_W-1:0]   avs_byteenable,
   output logic      [prc_pkg::DATA_W-1:0] avs_readdata,
   output logic                            avs_waitrequest,
   input  wire logic                       boost_mode,
   input  wire logic                       auto_join_request,
   input  wire logic                       sleep_mode,
   input  wire logic [prc_pkg::XT_W-1:0]   crystal_trim_value,
   output logic                            rail_join_switch_closed,
   output logic                            high_rail_monitor_hysteresis_off,
   output logic                            high_rail_monitor_hysteresis_level,
   output logic                            high_rail_monitor_off,
   output logic                            low_rail_monitor_hysteresis_off,
   output logic                            low_rail_monitor_hysteresis_level,
   output logic                            low_rail_monitor_off,
   output logic                            core_reg_pump_off,
   output logic                            regulator_reference_hold,
   output logic                            core_regulator_off,
   output logic                            core_regulator_retention_on,
   output logic                            high_rail_good_cmp_on,
   output logic                            high_rail_bad_cmp_on,
   output logic                            low_regulator_on,
   output logic                            low_regulator_high_current,
   output logic      [prc_pkg::MV_W-1:0]   converter_level_mv,
   output logic      [prc_pkg::MV_W-1:0]   crystal_regulator_level_mv,
   output logic      [prc_pkg::MV_W-1:0]   low_regulator_level_mv
);

   prc_bus_e          state_ff;
   prc_bus_e          nxt_state;
   logic              wait_ff;
   logic              nxt_wait;
   logic [DATA_W-1:0] rdata_ff;
   logic [DATA_W-1:0] nxt_rdata;
   logic [REG_W-1:0]  ctrl_ff;
   logic [REG_W-1:0]  nxt_ctrl;
   logic [REG_W-1:0]  lvl_ff;
   logic [REG_W-1:0]  nxt_lvl;
   logic [XT_W-1:0]   xtal_ff;
   logic [XT_W-1:0]   nxt_xtal;
   logic              join_ff;
   logic              nxt_join;
   logic              req;
   logic              accept_wr;

   // byte-lane merge; only the low two lanes carry register bits
   function automatic logic [REG_W-1:0] lane_merge(
      input logic [REG_W-1:0]  old,
      input logic [DATA_W-1:0] wd,
      input logic [BE_W-1:0]   be,
      input logic [REG_W-1:0]  mask);
      logic [REG_W-1:0] v;
      v = old;
      if (be[0]) begin
         v[7:0] = wd[7:0];
      end
      if (be[1]) begin
         v[15:8] = wd[15:8];
      end
      return (v & mask) | (old & ~mask);
   endfunction

   function automatic logic [DATA_W-1:0] read_word(
      input logic [ADDR_W-1:0] a,
      input logic [REG_W-1:0]  c,
      input logic [REG_W-1:0]  l,
      input logic [XT_W-1:0]   x);
      logic [DATA_W-1:0] v;
      v = '0;
      if (a == PWR_CTRL_IDX) begin
         v = {16'h0000, c};
      end else if (a == PWR_LEVEL_IDX) begin
         v = {16'h0000, l & LEVEL_MASK};
      end else if (a == XTAL_STAT_IDX) begin
         v = {24'h00_0000, x};
      end
      return v;
   endfunction

   assign req       = avs_read || avs_write;
   assign accept_wr = (state_ff == PRC_BUS_ANSWER) && avs_write;

   // one wait cycle: answer comes on the cycle after the request is seen
   always_comb begin
      nxt_state = state_ff;
      nxt_wait  = 1'b1;
      nxt_rdata = rdata_ff;
      unique case (state_ff)
         PRC_BUS_IDLE: begin
            if (req) begin
               nxt_state = PRC_BUS_ANSWER;
               nxt_wait  = 1'b0;
               nxt_rdata = avs_read ?
                  read_word(avs_address, ctrl_ff, lvl_ff, xtal_ff) :
                  '0; // see R15
            end
         end
         PRC_BUS_ANSWER: begin
            nxt_state = PRC_BUS_IDLE;
            nxt_wait  = 1'b1;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         state_ff <= PRC_BUS_IDLE;
         wait_ff  <= 1'b1;
         rdata_ff <= '0;
      end else begin
         state_ff <= nxt_state;
         wait_ff  <= nxt_wait;
         rdata_ff <= nxt_rdata;
      end
   end

   // writes land at the edge the master sees waitrequest low
   always_comb begin
      nxt_ctrl = ctrl_ff;
      nxt_lvl  = lvl_ff;
      if (accept_wr && avs_address == PWR_CTRL_IDX) begin
         nxt_ctrl = lane_merge(ctrl_ff, avs_writedata, avs_byteenable,
                               CTRL_MASK); // see R03 R04 R05 R07 R14
      end
      if (accept_wr && avs_address == PWR_LEVEL_IDX) begin
         nxt_lvl = lane_merge(lvl_ff, avs_writedata, avs_byteenable,
                              LEVEL_MASK); // see R08
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         ctrl_ff <= CTRL_RESET; // see R13
         lvl_ff  <= LEVEL_RESET; // see R11
      end else begin
         ctrl_ff <= nxt_ctrl;
         lvl_ff  <= nxt_lvl;
      end
   end

   // readback follows the oscillator, no bus path writes it
   always_comb begin
      nxt_xtal = crystal_trim_value; // see R12
   end

   // automatic join outside boost keeps the switch open, safer default
   always_comb begin
      if (ctrl_ff[JOIN_MODE_BIT]) begin
         nxt_join = boost_mode && auto_join_request; // see R01
      end else begin
         nxt_join = ctrl_ff[JOIN_CLOSE_BIT]; // see R02
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         xtal_ff <= XTAL_RESET;
         join_ff <= 1'b0;
      end else begin
         xtal_ff <= nxt_xtal;
         join_ff <= nxt_join;
      end
   end

   prc_low_reg_decode u_low_mode (
      .clk          (clk),
      .reset_n      (reset_n),
      .mode         (ctrl_ff[LOW_MODE_LSB +: 2]), // see R06
      .sleep_mode   (sleep_mode),
      .reg_on       (low_regulator_on),
      .high_current (low_regulator_high_current)
   );

   prc_trim_level #(.RESET_MV(CONV_1V8_MV)) u_conv_trim (
      .clk        (clk),
      .reset_n    (reset_n),
      .nominal_mv (prc_conv_nominal(lvl_ff[CONV_LEVEL_LSB +: 2])),
      .code       (lvl_ff[CONV_TRIM_LSB +: TRIM_W]), // see R08
      .level_mv   (converter_level_mv)
   );

   prc_trim_level #(.RESET_MV(XTAL_NOM_MV)) u_xtal_trim (
      .clk        (clk),
      .reset_n    (reset_n),
      .nominal_mv (XTAL_NOM_MV),
      .code       (lvl_ff[XTAL_TRIM_LSB +: TRIM_W]), // see R09
      .level_mv   (crystal_regulator_level_mv)
   );

   prc_trim_level #(.RESET_MV(12'h4B0)) u_low_trim (
      .clk        (clk),
      .reset_n    (reset_n),
      .nominal_mv (LOW_NOM_MV),
      .code       (lvl_ff[LOW_TRIM_LSB +: TRIM_W]), // see R10
      .level_mv   (low_regulator_level_mv)
   );

   assign avs_readdata                       = rdata_ff;
   assign avs_waitrequest                    = wait_ff;
   assign rail_join_switch_closed            = join_ff;
   assign high_rail_monitor_hysteresis_off   = ctrl_ff[HI_HYST_OFF_BIT];
   assign high_rail_monitor_hysteresis_level = ctrl_ff[HI_HYST_LVL_BIT];
   assign high_rail_monitor_off              = ctrl_ff[HI_MON_OFF_BIT];
   assign low_rail_monitor_hysteresis_off    = ctrl_ff[LO_HYST_OFF_BIT];
   assign low_rail_monitor_hysteresis_level  = ctrl_ff[LO_HYST_LVL_BIT];
   assign low_rail_monitor_off               = ctrl_ff[LO_MON_OFF_BIT];
   assign core_reg_pump_off                  = ctrl_ff[PUMP_OFF_BIT];
   assign regulator_reference_hold           = ctrl_ff[REF_HOLD_BIT];
   assign core_regulator_off                 = ctrl_ff[CORE_OFF_BIT];
   assign core_regulator_retention_on        = ctrl_ff[CORE_RET_BIT];
   assign high_rail_good_cmp_on              = ctrl_ff[HI_OK_EN_BIT];
   assign high_rail_bad_cmp_on               = ctrl_ff[HI_NOK_EN_BIT];

   join_manual_a: assert property (@(posedge clk) disable iff (!reset_n)
      !ctrl_ff[JOIN_MODE_BIT] |=> join_ff == $past(ctrl_ff[JOIN_CLOSE_BIT]))
      else $error("manual join does not follow connect bit"); // see R02

   join_auto_a: assert property (@(posedge clk) disable iff (!reset_n)
      ctrl_ff[JOIN_MODE_BIT] && !boost_mode |=> !join_ff)
      else $error("auto join closed outside boost"); // see R01

   hyst_level_a: assert property (@(posedge clk) disable iff (!reset_n)
      accept_wr && avs_address == PWR_CTRL_IDX && avs_byteenable[1]
      |=> high_rail_monitor_hysteresis_level == $past(avs_writedata[13])
          && low_rail_monitor_hysteresis_level == $past(avs_writedata[10]))
      else $error("hysteresis level not written"); // see R03

   pump_off_a: assert property (@(posedge clk) disable iff (!reset_n)
      accept_wr && avs_address == PWR_CTRL_IDX && avs_byteenable[1]
      |=> core_reg_pump_off == $past(avs_writedata[8]))
      else $error("pump disable not written"); // see R04

   ref_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
      accept_wr && avs_address == PWR_CTRL_IDX && avs_byteenable[0]
      |=> regulator_reference_hold == $past(avs_writedata[7])
          && core_regulator_retention_on == $past(avs_writedata[3]))
      else $error("hold or retention not written"); // see R05 R07

   low_off_a: assert property (@(posedge clk) disable iff (!reset_n)
      ctrl_ff[LOW_MODE_LSB +: 2] == 2'h1 |=> !low_regulator_on)
      else $error("low regulator on in off mode"); // see R06

   low_both_a: assert property (@(posedge clk) disable iff (!reset_n)
      ctrl_ff[LOW_MODE_LSB +: 2] == 2'h2
      |=> low_regulator_on && !low_regulator_high_current)
      else $error("low regulator not low current"); // see R06

   low_level_a: assert property (@(posedge clk) disable iff (!reset_n)
      1'b1 |=> int'(low_regulator_level_mv) ==
         1100 + 25 * (int'($past(lvl_ff[3:1])) - 3))
      else $error("low regulator level wrong"); // see R10

   xtal_level_a: assert property (@(posedge clk) disable iff (!reset_n)
      1'b1 |=> int'(crystal_regulator_level_mv) ==
         900 + 25 * (int'($past(lvl_ff[6:4])) - 3))
      else $error("crystal regulator level wrong"); // see R09

   conv_trim_a: assert property (@(posedge clk) disable iff (!reset_n)
      lvl_ff[CONV_LEVEL_LSB +: 2] == 2'h1 && lvl_ff[13:11] == 3'h7
      |=> converter_level_mv == 12'h76C)
      else $error("converter trim top code wrong"); // see R08

   reset_val_a: assert property (@(posedge clk)
      !reset_n |=> ctrl_ff == 16'h4000 && lvl_ff[3:1] == 3'h7
                   && lvl_ff[13:11] == 3'h3 && lvl_ff[6:4] == 3'h3)
      else $error("reset values wrong"); // see R11 R13

   xtal_ro_a: assert property (@(posedge clk) disable iff (!reset_n)
      1'b1 |=> xtal_ff == $past(crystal_trim_value))
      else $error("crystal readback not tracking"); // see R12

   rd_zero_a: assert property (@(posedge clk) disable iff (!reset_n)
      avs_read && !avs_waitrequest
      |-> avs_readdata[31:16] == 16'h0000
          && (avs_address != PWR_LEVEL_IDX
              || (avs_readdata[15:0] & ~LEVEL_MASK) == 16'h0000))
      else $error("reserved bits not zero"); // see R15

   rd_ctrl_a: assert property (@(posedge clk) disable iff (!reset_n)
      avs_read && !avs_waitrequest && avs_address == PWR_CTRL_IDX
      |-> avs_readdata[15:0] == ctrl_ff)
      else $error("control readback wrong"); // see R15

   bus_wait_a: assert property (@(posedge clk) disable iff (!reset_n)
      (avs_read || avs_write) |-> ##[0:1] !avs_waitrequest)
      else $error("bus answer too late"); // see R15

endmodule

// [tb_prc_regs.sv]
`timescale 1ns/100ps
module tb_prc_regs;
   import prc_pkg::*;

   logic              clk;
   logic              reset_n;
   logic [ADDR_W-1:0] avs_address;
   logic              avs_read;
   logic              avs_write;
   logic [DATA_W-1:0] avs_writedata;
   logic [BE_W-1:0]   avs_byteenable;
   logic [DATA_W-1:0] avs_readdata;
   logic              avs_waitrequest;
   logic              boost_mode;
   logic              auto_join_request;
   logic              sleep_mode;
   logic [XT_W-1:0]   crystal_trim_value;
   logic              join_closed;
   logic              hi_hyst_off, hi_hyst_lvl, hi_mon_off;
   logic              lo_hyst_off, lo_hyst_lvl, lo_mon_off;
   logic              pump_off, ref_hold, core_off, core_ret;
   logic              good_on, bad_on, low_on, low_high;
   logic [MV_W-1:0]   conv_mv;
   logic [MV_W-1:0]   xreg_mv;
   logic [MV_W-1:0]   lreg_mv;
   logic [15:0]       ctl_vec;
   int                err_total;
   int                checked;
   int                cycles;

   // control lines laid out at their register bit positions
   assign ctl_vec = {1'b0, hi_hyst_off, hi_hyst_lvl, hi_mon_off, lo_hyst_off,
                     lo_hyst_lvl, lo_mon_off, pump_off, ref_hold, 2'b00,
                     core_off, core_ret, 1'b0, good_on, bad_on};

   prc_regs prc_regs_inst (
      .clk                                (clk),
      .reset_n                            (reset_n),
      .avs_address                        (avs_address),
      .avs_read                           (avs_read),
      .avs_write                          (avs_write),
      .avs_writedata                      (avs_writedata),
      .avs_byteenable                     (avs_byteenable),
      .avs_readdata                       (avs_readdata),
      .avs_waitrequest                    (avs_waitrequest),
      .boost_mode                         (boost_mode),
      .auto_join_request                  (auto_join_request),
      .sleep_mode                         (sleep_mode),
      .crystal_trim_value                 (crystal_trim_value),
      .rail_join_switch_closed            (join_closed),
      .high_rail_monitor_hysteresis_off   (hi_hyst_off),
      .high_rail_monitor_hysteresis_level (hi_hyst_lvl),
      .high_rail_monitor_off              (hi_mon_off),
      .low_rail_monitor_hysteresis_off    (lo_hyst_off),
      .low_rail_monitor_hysteresis_level  (lo_hyst_lvl),
      .low_rail_monitor_off               (lo_mon_off),
      .core_reg_pump_off                  (pump_off),
      .regulator_reference_hold           (ref_hold),
      .core_regulator_off                 (core_off),
      .core_regulator_retention_on        (core_ret),
      .high_rail_good_cmp_on              (good_on),
      .high_rail_bad_cmp_on               (bad_on),
      .low_regulator_on                   (low_on),
      .low_regulator_high_current         (low_high),
      .converter_level_mv                 (conv_mv),
      .crystal_regulator_level_mv         (xreg_mv),
      .low_regulator_level_mv             (lreg_mv)
   );

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic tally_and_finish();
      $display("checks %0d errors %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                        input string what);
      checked++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] %0t %s: seen %h expected %h", $time, what, seen,
                  exp);
      end
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge clk);
   endtask

   // edge-sampled reads see pre-update values, so waitrequest is safe here
   task automatic bus(input logic wr, input logic [ADDR_W-1:0] a,
                      input logic [15:0] d, input logic [BE_W-1:0] be,
                      output logic [31:0] rd);
      int n;
      @(posedge clk);
      n = 0;
      avs_address <= a;
      avs_writedata <= {16'h0000, d};
      avs_byteenable <= be;
      avs_write <= wr;
      avs_read <= ~wr;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      check(n, 32'h0000_0002, "bus wait cycles");
   endtask

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [15:0] d);
      logic [31:0] rd;
      bus(1'b1, a, d, 4'hF, rd);
   endtask

   task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [31:0] exp,
                        input string what);
      logic [31:0] rd;
      bus(1'b0, a, 16'h0000, 4'hF, rd);
      check(rd, exp, what);
   endtask

   function automatic logic [1:0] exp_low(input int c, input int s);
      case (c)
         0: return s ? 2'h0 : 2'h3;
         1: return 2'h0;
         2: return 2'h2;
         default: return s ? 2'h2 : 2'h3;
      endcase
   endfunction

   task automatic t_reset_vals();
      rdchk(PWR_CTRL_IDX, 32'h0000_4000, "ctrl reset");
      rdchk(PWR_LEVEL_IDX, 32'h0000_1A3E, "level reset");
      check({16'h0000, ctl_vec}, 32'h0000_4000, "lines reset");
      check(32'(join_closed), 32'h0000_0000, "join reset");
      check({20'h0, conv_mv}, 32'h0000_0708, "conv reset");
      check({20'h0, xreg_mv}, 32'h0000_0384, "xtal reset");
      check({20'h0, lreg_mv}, 32'h0000_04B0, "low reset");
   endtask

   task automatic t_ctrl_walk();
      for (int i = 0; i < 16; i++) begin
         wr(PWR_CTRL_IDX, 16'h0001 << i);
         idle(2);
         rdchk(PWR_CTRL_IDX, 32'h0000_0001 << i, "ctrl readback");
         check({16'h0000, ctl_vec}, (32'h0000_0001 << i) & 32'h0000_7F9B,
               "ctrl lines");
         check(32'(join_closed), 32'(i == 2), "join walk");
      end
   endtask

   // automatic mode with the manual bit set: manual bit must not leak
   task automatic t_join();
      boost_mode <= 1'b0;
      auto_join_request <= 1'b1;
      wr(PWR_CTRL_IDX, 16'h8004);
      idle(3);
      check(32'(join_closed), 32'h0000_0000, "auto no boost");
      boost_mode <= 1'b1;
      idle(3);
      check(32'(join_closed), 32'h0000_0001, "auto boost");
      auto_join_request <= 1'b0;
      idle(3);
      check(32'(join_closed), 32'h0000_0000, "auto released");
      wr(PWR_CTRL_IDX, 16'h0004);
      idle(3);
      check(32'(join_closed), 32'h0000_0001, "manual close");
      wr(PWR_CTRL_IDX, 16'h0000);
      idle(3);
      check(32'(join_closed), 32'h0000_0000, "manual open");
   endtask

   task automatic t_low_mode();
      for (int c = 0; c < 4; c++) begin
         for (int s = 0; s < 2; s++) begin
            sleep_mode <= s[0];
            wr(PWR_CTRL_IDX, 16'(c << 5));
            idle(3);
            check({30'h0, low_on, low_high}, 32'(exp_low(c, s)),
                  "low mode");
         end
      end
   endtask

   // reserved bits written high on purpose; they must read back zero
   task automatic t_levels();
      logic [MV_W-1:0] noms [4] = '{12'h44C, 12'h708, 12'h9C4, 12'hBB8};
      logic [15:0]     d;
      for (int c = 0; c < 8; c++) begin
         d = 16'((c << 11) | ((c % 4) << 9) | (c << 4) | (c << 1));
         wr(PWR_LEVEL_IDX, d | 16'hC181);
         idle(2);
         rdchk(PWR_LEVEL_IDX, {16'h0000, d}, "level readback");
         check({20'h0, conv_mv}, 32'(noms[c % 4] + 25 * c - 75),
               "conv mv");
         check({20'h0, xreg_mv}, 32'(12'h384 + 25 * c - 75),
               "xtal mv");
         check({20'h0, lreg_mv}, 32'(12'h44C + 25 * c - 75),
               "low mv");
      end
      // 1.8 V nominal with the top trim code
      wr(PWR_LEVEL_IDX, 16'h3A00);
      idle(2);
      check({20'h0, conv_mv}, 32'h0000_076C, "conv top code");
   endtask

   task automatic t_access();
      logic [31:0] rd;
      crystal_trim_value <= 8'hA5;
      idle(2);
      rdchk(XTAL_STAT_IDX, 32'h0000_00A5, "trim view");
      wr(XTAL_STAT_IDX, 16'h005A);
      rdchk(XTAL_STAT_IDX, 32'h0000_00A5, "trim view written");
      wr(PWR_CTRL_IDX, 16'h1234);
      wr(8'h10, 16'hFFFF);
      rdchk(8'h10, 32'h0000_0000, "unmapped read");
      rdchk(PWR_CTRL_IDX, 32'h0000_1234, "ctrl kept");
      bus(1'b1, PWR_CTRL_IDX, 16'h00FF, 4'h2, rd);
      rdchk(PWR_CTRL_IDX, 32'h0000_0034, "upper lane only");
   endtask

   task automatic t_reset_mid();
      wr(PWR_CTRL_IDX, 16'hFFFF);
      wr(PWR_LEVEL_IDX, 16'hFFFF);
      @(posedge clk);
      reset_n <= 1'b0;
      idle(2);
      reset_n <= 1'b1;
      t_reset_vals();
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == 10000) begin
         err_total++;
         tally_and_finish();
      end
   end

   initial begin
      reset_n = 1'b0;
      avs_address = '0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = '0;
      avs_byteenable = '0;
      boost_mode = 1'b0;
      auto_join_request = 1'b0;
      sleep_mode = 1'b0;
      crystal_trim_value = 8'h00;
      repeat (4) @(posedge clk);
      reset_n <= 1'b1;
      rdchk(XTAL_STAT_IDX, 32'h0000_0000, "trim view reset");
      t_reset_vals();
      t_ctrl_walk();
      t_join();
      t_low_mode();
      t_levels();
      t_access();
      t_reset_mid();
      tally_and_finish();
   end
endmodule
